/* core/bsf_pkg.sv */
// Shared constants, command codes and types of the boot sector flash host controller
package bsf_pkg;

  // Clock and bus cycle timing
  localparam int CLK_PERIOD_NS    = 4;
  localparam int T_ACCESS_NS      = 120;
  localparam int T_WRITE_PULSE_NS = 50;
  localparam int T_RECOVER_NS     = 30;
  localparam int T_HW_RESET_NS    = 500;
  localparam int ACC_CYC   = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC    = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC   = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (T_HW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W     = 8;
  localparam int POLL_LIMIT_DEFAULT = 1000000;

  // Array geometry
  localparam int ADDR_W   = 19;
  localparam int DATA_W   = 16;
  localparam int NUM_SECT = 11;
  localparam logic [ADDR_W-1:0] SECT_BASE [NUM_SECT] = '{
    19'h00000, 19'h04000, 19'h06000, 19'h08000, 19'h10000, 19'h20000,
    19'h30000, 19'h40000, 19'h50000, 19'h60000, 19'h70000};

  // Unlock locations in word and byte mode
  localparam logic [ADDR_W-1:0] UNLOCK1_WORD = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_WORD = 19'h002aa;
  localparam logic [ADDR_W-1:0] UNLOCK1_BYTE = 19'h00aaa;
  localparam logic [ADDR_W-1:0] UNLOCK2_BYTE = 19'h00555;

  // Command codes
  localparam logic [DATA_W-1:0] CODE_UNLOCK1     = 16'h00aa;
  localparam logic [DATA_W-1:0] CODE_UNLOCK2     = 16'h0055;
  localparam logic [DATA_W-1:0] CODE_PROGRAM     = 16'h00a0;
  localparam logic [DATA_W-1:0] CODE_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CODE_CHIP_ERASE  = 16'h0010;
  localparam logic [DATA_W-1:0] CODE_SECT_ERASE  = 16'h0030;
  localparam logic [DATA_W-1:0] CODE_SUSPEND     = 16'h00b0;
  localparam logic [DATA_W-1:0] CODE_RESUME      = 16'h0030;
  localparam logic [DATA_W-1:0] CODE_BYPASS      = 16'h0020;
  localparam logic [DATA_W-1:0] CODE_BYPASS_EXIT = 16'h0090;
  localparam logic [DATA_W-1:0] CODE_EXIT_DATA   = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_RESET       = 16'h00f0;

  // Status bit positions
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  typedef enum logic [3:0] {
    OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND,
    OP_RESUME, OP_BYPASS_ENTER, OP_BYPASS_EXIT, OP_RESET_CMD, OP_HW_RESET
  } bsf_op_type;

endpackage

/* core/bsf_cyc_if.sv */
// Request and answer signals for one flash bus cycle
interface bsf_cyc_if;
  import bsf_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport master (output req, output wr, output addr, output wdata,
                  input done, input rdata);
  modport slave  (input req, input wr, input addr, input wdata,
                  output done, output rdata);
endinterface

/* core/bsf_bus_cycle.sv */
// Single asynchronous read or write cycle on the flash pins
module bsf_bus_cycle import bsf_pkg::*; (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  bsf_cyc_if.slave               cyc,
  output logic                   chip_sel_n,
  output logic                   write_strobe_n,
  output logic                   output_drive_n,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      data_lines_out,
  output logic                   data_lines_oe_n,
  input  wire logic [DATA_W-1:0] data_lines_in
);
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} bsf_cyc_state_type;

  bsf_cyc_state_type state, next_state;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic              next_ce_n, next_we_n, next_oe_n, next_d_oe_n, next_done;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dout, next_rdata;

  // Next values; data is driven only in write cycles, so the pins never fight
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_ce_n   = chip_sel_n;
    next_we_n   = write_strobe_n;
    next_oe_n   = output_drive_n;
    next_d_oe_n = data_lines_oe_n;
    next_addr   = flash_addr;
    next_dout   = data_lines_out;
    next_rdata  = cyc.rdata;
    next_done   = 1'b0;
    unique case (state)
      CY_IDLE: begin
        if (cyc.req) begin
          next_state  = CY_SETUP;
          next_addr   = cyc.addr;
          next_dout   = cyc.wdata;
          next_ce_n   = 1'b0;
          next_oe_n   = cyc.wr;
          next_d_oe_n = ~cyc.wr;
        end
      end
      CY_SETUP: begin
        next_state = CY_STROBE;
        next_we_n  = ~cyc.wr;
        next_cnt   = cyc.wr ? CNT_W'(WP_CYC - 1) : CNT_W'(ACC_CYC - 1);
      end
      CY_STROBE: begin
        if (cnt == '0) begin
          next_state = CY_HOLD;
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_rdata = data_lines_in;
          next_cnt   = CNT_W'(REC_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      CY_HOLD: begin
        // Data stays driven one cycle past the strobe for hold time
        next_ce_n   = 1'b1;
        next_d_oe_n = 1'b1;
        if (cnt == '0) begin
          next_state = CY_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state           <= CY_IDLE;
      cnt             <= '0;
      chip_sel_n      <= 1'b1;
      write_strobe_n  <= 1'b1;
      output_drive_n  <= 1'b1;
      data_lines_oe_n <= 1'b1;
      flash_addr      <= '0;
      data_lines_out  <= '0;
      cyc.rdata       <= '0;
      cyc.done        <= 1'b0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      chip_sel_n      <= next_ce_n;
      write_strobe_n  <= next_we_n;
      output_drive_n  <= next_oe_n;
      data_lines_oe_n <= next_d_oe_n;
      flash_addr      <= next_addr;
      data_lines_out  <= next_dout;
      cyc.rdata       <= next_rdata;
      cyc.done        <= next_done;
    end
  end
endmodule

/* core/bsf_flash_host.sv */
// Host-side command sequencer for a boot sector parallel NOR flash
// Behaviour
// - Commands are plain write cycles carrying address and data.
// - In bypass mode a program takes two writes instead of four.
// - Completion is seen on ready/busy together with a steady toggle bit; the polling bit is not used.
// - The host may put the device in standby by its controls.
module bsf_flash_host import bsf_pkg::*; #(
  parameter int POLL_LIMIT = POLL_LIMIT_DEFAULT
) (
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire logic [3:0]          cmd_op,
  input  wire logic [ADDR_W-1:0]   cmd_addr,
  input  wire logic [DATA_W-1:0]   cmd_data,
  input  wire logic [NUM_SECT-1:0] cmd_sectors,
  input  wire logic                word_mode,
  input  wire logic [NUM_SECT-1:0] protect_mask,
  input  wire logic                temp_unprotect,
  output logic                     rsp_valid,
  output logic [DATA_W-1:0]        rsp_data,
  output logic                     rsp_error,
  output logic                     chip_sel_n,
  output logic                     write_strobe_n,
  output logic                     output_drive_n,
  output logic                     flash_reset_n,
  output logic                     flash_word_mode,
  output logic [ADDR_W-1:0]        flash_addr,
  output logic [DATA_W-1:0]        data_lines_out,
  output logic                     data_lines_oe_n,
  input  wire logic [DATA_W-1:0]   data_lines_in,
  input  wire logic                ready_busy_out
);
  typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_POLL_A, ST_POLL_B, ST_RESP, ST_HWRESET}
    bsf_state_type;

  bsf_cyc_if cyc ();

  bsf_state_type      state, next_state;
  bsf_op_type         op, next_op;
  logic [ADDR_W-1:0]  loc, next_loc;
  logic [DATA_W-1:0]  wdata, next_wdata;
  logic [NUM_SECT-1:0] sect_left, next_sect_left;
  logic [NUM_SECT-1:0] erasing, next_erasing;
  logic               suspended, next_suspended;
  logic               bypass, next_bypass;
  logic [2:0]         step, next_step;
  logic               issued, next_issued;
  logic [DATA_W-1:0]  poll_prev, next_poll_prev;
  logic [31:0]        poll_cnt, next_poll_cnt;
  logic [CNT_W-1:0]   rst_cnt, next_rst_cnt;
  logic               next_cmd_ready, next_rsp_valid, next_rsp_error, next_rst_n, next_wmode;
  logic [DATA_W-1:0]  next_rsp_data;

  // Step table outputs
  logic [ADDR_W-1:0]  st_addr;
  logic [DATA_W-1:0]  st_data;
  logic               st_read, st_last, st_polled;
  logic [ADDR_W-1:0]  u1, u2;
  logic [NUM_SECT-1:0] low_bit;
  logic [NUM_SECT-1:0] req_sect;
  bsf_op_type         in_op;

  // Sector holding a location in the current bus mode
  function automatic logic [NUM_SECT-1:0] sect_of(input logic [ADDR_W-1:0] l,
                                                  input logic wm);
    logic [ADDR_W-1:0]   b;
    logic [NUM_SECT-1:0] s;
    b = wm ? {l[ADDR_W-2:0], 1'b0} : l;
    s = '0;
    for (int i = 0; i < NUM_SECT; i++) begin
      if (b >= SECT_BASE[i]) s = NUM_SECT'(1) << i;
    end
    return s;
  endfunction

  // Base location of a one-hot sector in the current bus mode
  function automatic logic [ADDR_W-1:0] base_of(input logic [NUM_SECT-1:0] s,
                                                input logic wm);
    logic [ADDR_W-1:0] b;
    b = '0;
    for (int i = 0; i < NUM_SECT; i++) begin
      if (s[i]) b = SECT_BASE[i];
    end
    return wm ? {1'b0, b[ADDR_W-1:1]} : b;
  endfunction

  assign u1      = flash_word_mode ? UNLOCK1_WORD : UNLOCK1_BYTE;
  assign u2      = flash_word_mode ? UNLOCK2_WORD : UNLOCK2_BYTE;
  assign low_bit = sect_left & (~sect_left + 1'b1);
  assign in_op   = bsf_op_type'(cmd_op);

  // Bus cycle, a read for OP_READ and a write otherwise, for the current step of the current operation
  always_comb begin
    st_addr   = u1;
    st_data   = CODE_UNLOCK1;
    st_read   = 1'b0;
    st_last   = 1'b0;
    st_polled = 1'b1;
    unique case (step)
      3'd1: begin
        st_addr = u2;
        st_data = CODE_UNLOCK2;
      end
      3'd2: st_data = CODE_ERASE_SETUP;
      3'd4: begin
        st_addr = u2;
        st_data = CODE_UNLOCK2;
      end
      default: ;
    endcase
    unique case (op)
      OP_READ: begin
        st_addr   = loc;
        st_read   = 1'b1;
        st_last   = 1'b1;
        st_polled = 1'b0;
      end
      OP_PROGRAM: begin
        if (step == 3'd2) st_data = CODE_PROGRAM;
        if (step == 3'd3) begin
          st_addr = loc;
          st_data = wdata;
          st_last = 1'b1;
        end
      end
      OP_CHIP_ERASE: begin
        if (step == 3'd5) begin
          st_data = CODE_CHIP_ERASE;
          st_last = 1'b1;
        end
      end
      OP_SECTOR_ERASE: begin
        if (step == 3'd5) begin
          st_addr = base_of(low_bit, flash_word_mode);
          st_data = CODE_SECT_ERASE;
          st_last = (sect_left == low_bit);
        end
      end
      OP_SUSPEND: begin
        st_data = CODE_SUSPEND;
        st_last = 1'b1;
      end
      OP_RESUME: begin
        st_data   = CODE_RESUME;
        st_last   = 1'b1;
        st_polled = 1'b0;
      end
      OP_BYPASS_ENTER: begin
        if (step == 3'd2) begin
          st_data   = CODE_BYPASS;
          st_last   = 1'b1;
          st_polled = 1'b0;
        end
      end
      OP_BYPASS_EXIT: begin
        st_data   = (step == 3'd0) ? CODE_BYPASS_EXIT : CODE_EXIT_DATA;
        st_last   = (step == 3'd1);
        st_polled = 1'b0;
      end
      OP_RESET_CMD: begin
        st_data   = CODE_RESET;
        st_last   = 1'b1;
        st_polled = 1'b0;
      end
      OP_HW_RESET: st_polled = 1'b0;
      default: ;  // A refused code may sit in op
    endcase
  end

  // Sectors a new request would touch
  always_comb begin
    unique case (in_op)
      OP_PROGRAM:      req_sect = sect_of(cmd_addr, word_mode);
      OP_SECTOR_ERASE: req_sect = cmd_sectors;
      OP_CHIP_ERASE:   req_sect = '1;
      default:         req_sect = '0;
    endcase
  end

  // Sequencer next values
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_loc       = loc;
    next_wdata     = wdata;
    next_sect_left = sect_left;
    next_erasing   = erasing;
    next_suspended = suspended;
    next_bypass    = bypass;
    next_step      = step;
    next_issued    = 1'b0;
    next_poll_prev = poll_prev;
    next_poll_cnt  = poll_cnt;
    next_rst_cnt   = rst_cnt;
    next_rst_n     = 1'b1;
    next_wmode     = flash_word_mode;
    next_rsp_valid = 1'b0;
    next_rsp_error = rsp_error;
    next_rsp_data  = rsp_data;
    cyc.req        = 1'b0;
    cyc.wr         = ~st_read;
    cyc.addr       = st_addr;
    cyc.wdata      = flash_word_mode ? st_data : {8'h00, st_data[7:0]};
    unique case (state)
      ST_IDLE: begin
        // With no request the chip select stays high: standby and sleep for the device
        if (cmd_valid) begin
          next_op        = in_op;
          next_wmode     = word_mode;
          next_loc       = word_mode ? {1'b0, cmd_addr[ADDR_W-2:0]} : cmd_addr;
          next_wdata     = cmd_data;
          next_sect_left = cmd_sectors;
          next_step      = (in_op == OP_PROGRAM && bypass) ? 3'd2 : 3'd0;
          next_rsp_error = 1'b0;
          next_rsp_data  = '0;
          next_state     = ST_SEQ;
          if (in_op > OP_HW_RESET ||
              (in_op == OP_SECTOR_ERASE && cmd_sectors == '0) ||
              (bypass && in_op != OP_PROGRAM && in_op != OP_BYPASS_EXIT &&
               in_op != OP_HW_RESET && in_op != OP_READ) ||
              (suspended && in_op != OP_READ && in_op != OP_PROGRAM &&
               in_op != OP_RESUME && in_op != OP_HW_RESET)) begin
            next_rsp_error = 1'b1;
            next_state     = ST_RESP;
          end else if (|(req_sect & protect_mask) && !temp_unprotect) begin
            next_rsp_error = 1'b1;
            next_state     = ST_RESP;
          end else if (suspended && |(req_sect & erasing)) begin
            next_rsp_error = 1'b1;
            next_state     = ST_RESP;
          end else if (in_op == OP_HW_RESET) begin
            next_rst_cnt = CNT_W'(RESET_CYC - 1);
            next_state   = ST_HWRESET;
          end
        end
      end
      ST_SEQ: begin
        cyc.req     = ~issued & ~cyc.done;
        next_issued = (issued | cyc.req) & ~cyc.done;
        if (cyc.done) begin
          if (st_read) next_rsp_data = flash_word_mode ? cyc.rdata : {8'h00, cyc.rdata[7:0]};
          if (op == OP_SECTOR_ERASE && step == 3'd5) begin
            next_sect_left = sect_left & ~low_bit;
            next_erasing   = erasing | low_bit;
          end
          if (!st_last) begin
            if (!(op == OP_SECTOR_ERASE && step == 3'd5)) next_step = step + 1'b1;
          end else begin
            unique case (op)
              OP_BYPASS_ENTER: next_bypass = 1'b1;
              OP_BYPASS_EXIT:  next_bypass = 1'b0;
              OP_RESET_CMD:    next_suspended = 1'b0;
              OP_SUSPEND:      next_suspended = |erasing;
              OP_RESUME:       next_suspended = 1'b0;
              OP_CHIP_ERASE:   next_erasing = '1;
              default: ;
            endcase
            next_poll_cnt = '0;
            next_state    = st_polled ? ST_POLL_A : ST_RESP;
          end
        end
      end
      ST_POLL_A, ST_POLL_B: begin
        // Status reads; the toggle bit stops once the embedded algorithm ends
        cyc.req     = ~issued & ~cyc.done;
        cyc.wr      = 1'b0;
        cyc.addr    = loc;
        next_issued = (issued | cyc.req) & ~cyc.done;
        if (cyc.done) begin
          next_poll_prev = cyc.rdata;
          next_poll_cnt  = poll_cnt + 1;
          if (state == ST_POLL_B && ready_busy_out &&
              cyc.rdata[TOGGLE_BIT] == poll_prev[TOGGLE_BIT]) begin
            next_rsp_data = cyc.rdata;
            next_state    = ST_RESP;
            if (op != OP_SUSPEND && op != OP_PROGRAM) next_erasing = '0;
          end else if (poll_cnt >= 32'(POLL_LIMIT)) begin
            next_rsp_error = 1'b1;
            next_state     = ST_RESP;
          end else begin
            next_state = ST_POLL_B;
          end
        end
      end
      ST_RESP: begin
        next_rsp_valid = 1'b1;
        next_state     = ST_IDLE;
      end
      ST_HWRESET: begin
        next_rst_n     = 1'b0;
        next_bypass    = 1'b0;
        next_suspended = 1'b0;
        next_erasing   = '0;
        if (rst_cnt == '0) next_state = ST_RESP;
        else next_rst_cnt = rst_cnt - 1'b1;
      end
    endcase
    next_cmd_ready = (next_state == ST_IDLE);
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state           <= ST_IDLE;
      op              <= OP_READ;
      loc             <= '0;
      wdata           <= '0;
      sect_left       <= '0;
      erasing         <= '0;
      suspended       <= 1'b0;
      bypass          <= 1'b0;
      step            <= '0;
      issued          <= 1'b0;
      poll_prev       <= '0;
      poll_cnt        <= '0;
      rst_cnt         <= '0;
      cmd_ready       <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_error       <= 1'b0;
      rsp_data        <= '0;
      flash_reset_n   <= 1'b0;
      flash_word_mode <= 1'b1;
    end else begin
      state           <= next_state;
      op              <= next_op;
      loc             <= next_loc;
      wdata           <= next_wdata;
      sect_left       <= next_sect_left;
      erasing         <= next_erasing;
      suspended       <= next_suspended;
      bypass          <= next_bypass;
      step            <= next_step;
      issued          <= next_issued;
      poll_prev       <= next_poll_prev;
      poll_cnt        <= next_poll_cnt;
      rst_cnt         <= next_rst_cnt;
      cmd_ready       <= next_cmd_ready;
      rsp_valid       <= next_rsp_valid;
      rsp_error       <= next_rsp_error;
      rsp_data        <= next_rsp_data;
      flash_reset_n   <= next_rst_n;
      flash_word_mode <= next_wmode;
    end
  end

  bsf_bus_cycle u_cycle (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .cyc             (cyc.slave),
    .chip_sel_n      (chip_sel_n),
    .write_strobe_n  (write_strobe_n),
    .output_drive_n  (output_drive_n),
    .flash_addr      (flash_addr),
    .data_lines_out  (data_lines_out),
    .data_lines_oe_n (data_lines_oe_n),
    .data_lines_in   (data_lines_in)
  );
endmodule

/* sim/bsf_flash_host_properties.sv */
// Pin and handshake properties of the flash host controller
module bsf_flash_host_properties import bsf_pkg::*; (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic       rsp_valid,
  input wire logic       rsp_error,
  input wire logic       chip_sel_n,
  input wire logic       write_strobe_n,
  input wire logic       output_drive_n,
  input wire logic       flash_reset_n,
  input wire logic       data_lines_oe_n,
  input wire logic       ready_busy_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Pin discipline, strobe widths and command port timing
  property p_wr; !write_strobe_n |-> !chip_sel_n && output_drive_n; endproperty
  a_wr: assert property (p_wr) else $error("strobe outside write");
  property p_rd; !output_drive_n |-> data_lines_oe_n && !chip_sel_n; endproperty
  a_rd: assert property (p_rd) else $error("bus contention");
  property p_pw; $fell(write_strobe_n) |-> (!write_strobe_n) [*8]; endproperty
  a_pw: assert property (p_pw) else $error("short write pulse");
  property p_hr; $fell(flash_reset_n) |-> (!flash_reset_n) [*8]; endproperty
  a_hr: assert property (p_hr) else $error("short reset pulse");
  property p_rv; rsp_valid |=> !rsp_valid; endproperty
  a_rv: assert property (p_rv) else $error("long response");
  property p_tk; cmd_valid && cmd_ready |=> !cmd_ready; endproperty
  a_tk: assert property (p_tk) else $error("ready after take");
  property p_bad;
    cmd_valid && cmd_ready && cmd_op > 4'h9 |-> ##1 chip_sel_n ##1 chip_sel_n && rsp_error;
  endproperty
  a_bad: assert property (p_bad) else $error("bad op not refused");
  property p_ok; rsp_valid && !rsp_error |-> ready_busy_out; endproperty
  a_ok: assert property (p_ok) else $error("done while busy");
  property p_idle; cmd_ready |-> chip_sel_n && write_strobe_n; endproperty
  a_idle: assert property (p_idle) else $error("selected in idle");
endmodule

/* sim/bsf_flash_model.sv */
// Behavioural parallel flash device for the host controller bench
module bsf_flash_model import bsf_pkg::*; (
  input  wire logic                chip_sel_n,
  input  wire logic                write_strobe_n,
  input  wire logic                output_drive_n,
  input  wire logic                flash_reset_n,
  input  wire logic                flash_word_mode,
  input  wire logic [ADDR_W-1:0]   flash_addr,
  input  wire logic [DATA_W-1:0]   data_lines_out,
  input  wire logic [NUM_SECT-1:0] prot,
  input  wire logic                unprot,
  output logic      [DATA_W-1:0]   data_lines_in,
  output logic                     ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic [7:0] d, pd;
  int         n, b;
  bit         pg, byp, tg;
  initial {ready_busy_out, n} = {1'b1, 32'd0};
  // Byte address of the location in either bus width
  always_comb b = flash_word_mode ? {flash_addr[17:0], 1'b0} : flash_addr;
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  function automatic int sect(int a);
    sect = 0;
    for (int k = 0; k < NUM_SECT; k++) if (a >= SECT_BASE[k]) sect = k;
  endfunction
  task automatic run(int t);
    ready_busy_out = 1'b0;
    ready_busy_out <= #(t) 1'b1;
  endtask
  // Erase skips locked bytes; a sector erase never touches other sectors, a chip erase clears all of them
  task automatic ers(int k);
    foreach (mem[a]) if ((k < 0 || sect(a) == k) && !(prot[sect(a)] && !unprot)) mem[a] = 8'hff;
    pd = 8'hff;
    run(400);
  endtask
  // Command decode on the closing edge of each write strobe
  always @(posedge write_strobe_n) if (!chip_sel_n && flash_reset_n) begin
    d = data_lines_out[7:0];
    if (pg) begin
      pg = 0;
      if (!(prot[sect(b)] && !unprot)) begin
        mem[b] = rd(b) & d;
        if (flash_word_mode) mem[b + 1] = rd(b + 1) & data_lines_out[15:8];
        pd = d;
        run(200);
      end
    end else if (byp) {pg, byp} = {d == 8'ha0, d != 8'h00};
    else case (n)
      2: {pg, byp, n} = {d == 8'ha0, d == 8'h20, (d == 8'h80) ? 32'd3 : 32'd0};
      5: if (d == 8'h30) ers(sect(b));
         else if (d == 8'h10) begin
           ers(-1);
           n = 0;
         end else n = d == 8'haa;
      default: n = (d == ((n % 3) ? 8'h55 : 8'haa)) ? n + 1 : int'(d == 8'haa);
    endcase
  end
  // Hardware reset drops any sequence and algorithm
  always @(negedge flash_reset_n) {n, pg, byp, ready_busy_out} = {32'd0, 3'b001};
  // Status toggles on each read while busy
  always @(negedge output_drive_n) if (!ready_busy_out) tg = !tg;
  // Released lines show an altered value so a stale sample cannot pass
  always @(chip_sel_n, output_drive_n, b, ready_busy_out, tg)
    if (chip_sel_n || output_drive_n) data_lines_in = ~{rd(b + 1), rd(b)};
    else if (!ready_busy_out) data_lines_in = {8'h00, ~pd[7], tg, 6'h00};
    else data_lines_in = {flash_word_mode ? rd(b + 1) : rd(b) ^ 8'h3c, rd(b)};
endmodule

/* sim/tb.sv */
// Self-checking bench of the flash host controller with a flash model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bsf_pkg::*;
  logic                sys_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, word_mode = 1'b1;
  logic                temp_unprotect = 1'b0, err;
  logic [3:0]          cmd_op = 4'h0;
  logic [ADDR_W-1:0]   cmd_addr = '0, flash_addr;
  logic [DATA_W-1:0]   cmd_data = '0, rsp_data, data_lines_out, data_lines_in, rsp;
  logic [NUM_SECT-1:0] cmd_sectors = '0, protect_mask = '0;
  logic                cmd_ready, rsp_valid, rsp_error, chip_sel_n, write_strobe_n;
  logic                output_drive_n, flash_reset_n, flash_word_mode, data_lines_oe_n;
  logic                ready_busy_out;
  int                  n_mismatch, cmp_count, n_wr;
  bsf_flash_host #(.POLL_LIMIT(20)) i_dut (.sys_clk, .reset_n, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_addr, .cmd_data, .cmd_sectors, .word_mode, .protect_mask, .temp_unprotect,
    .rsp_valid, .rsp_data, .rsp_error, .chip_sel_n, .write_strobe_n, .output_drive_n,
    .flash_reset_n, .flash_word_mode, .flash_addr, .data_lines_out, .data_lines_oe_n,
    .data_lines_in, .ready_busy_out);
  bsf_flash_model i_mem (.chip_sel_n, .write_strobe_n, .output_drive_n, .flash_reset_n,
    .flash_word_mode, .flash_addr, .data_lines_out, .prot(protect_mask),
    .unprot(temp_unprotect), .data_lines_in, .ready_busy_out);
  initial forever #2 sys_clk = ~sys_clk;
  // Counts device writes so unlock sequences can be measured
  always @(negedge write_strobe_n) n_wr++;
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One request, raised at a falling edge while ready, answer awaited boundedly
  task automatic cmd(input logic [3:0] op, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d = '0, input logic [NUM_SECT-1:0] s = '0);
    int t;
    t = 0;
    while (cmd_ready !== 1'b1 && t++ < 9999) @(negedge sys_clk);
    n_wr = 0;
    {cmd_op, cmd_addr, cmd_data, cmd_sectors, cmd_valid} = {op, a, d, s, 1'b1};
    @(negedge sys_clk) cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && t++ < 99999) @(negedge sys_clk);
    {rsp, err} = {rsp_data, rsp_error};
    if (t >= 99999) n_mismatch++;
  endtask
  task automatic t_word;
    cmd(OP_PROGRAM, 19'h00010, 16'h1234);
    chk(16'(n_wr), 16'h0004);
    chk(err, 1'b0);
    cmd(OP_READ, 19'h00010);
    chk(rsp, 16'h1234);
  endtask
  // Byte lane then the same bytes seen as one word
  task automatic t_byte;
    word_mode = 1'b0;
    cmd(OP_PROGRAM, 19'h00201, 16'hffc3);
    cmd(OP_READ, 19'h00201);
    chk(rsp, 16'h00c3);
    word_mode = 1'b1;
    cmd(OP_READ, 19'h00100);
    chk(rsp, 16'hc3ff);
  endtask
  task automatic t_bypass;
    cmd(OP_BYPASS_ENTER, 0);
    cmd(OP_PROGRAM, 19'h00011, 16'h5a5a);
    chk(16'(n_wr), 16'h0002);
    cmd(OP_CHIP_ERASE, 0);
    chk(err, 1'b1);
    cmd(OP_BYPASS_EXIT, 0);
    cmd(OP_READ, 19'h00011);
    chk(rsp, 16'h5a5a);
  endtask
  task automatic t_erase;
    cmd(OP_PROGRAM, 19'h08000, 16'h1111);
    cmd(OP_PROGRAM, 19'h10000, 16'h2222);
    cmd(OP_SECTOR_ERASE, 0, 0, 11'h010);
    cmd(OP_READ, 19'h08000);
    chk(rsp, 16'hffff);
    cmd(OP_READ, 19'h10000);
    chk(rsp, 16'h2222);
    cmd(OP_SECTOR_ERASE, 0, 0, 11'h000);
    chk(err, 1'b1);
    cmd(OP_CHIP_ERASE, 0);
    cmd(OP_READ, 19'h10000);
    chk(rsp, 16'hffff);
  endtask
  task automatic t_prot;
    protect_mask = 11'h040;
    cmd(OP_PROGRAM, 19'h18000, 16'h0f0f);
    chk(err, 1'b1);
    chk(16'(n_wr), 16'h0000);
    temp_unprotect = 1'b1;
    cmd(OP_PROGRAM, 19'h18000, 16'h0f0f);
    cmd(OP_READ, 19'h18000);
    chk(rsp, 16'h0f0f);
    {protect_mask, temp_unprotect} = '0;
  endtask
  // Unknown op, then a device reset in the middle of bypass mode
  task automatic t_reset;
    cmd(4'hb, 0);
    chk(err, 1'b1);
    cmd(OP_BYPASS_ENTER, 0);
    cmd(OP_HW_RESET, 0);
    chk(err, 1'b0);
    cmd(OP_PROGRAM, 19'h00030, 16'h7777);
    chk(16'(n_wr), 16'h0004);
    cmd(OP_READ, 19'h00030);
    chk(rsp, 16'h7777);
    cmd(OP_SUSPEND, 0);
    cmd(OP_RESUME, 0);
    chk(err, 1'b0);
    cmd(OP_RESET_CMD, 0);
    chk(16'(n_wr), 16'h0001);
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    t_word;
    t_byte;
    t_bypass;
    t_erase;
    t_prot;
    t_reset;
    test_done;
  end
  // The tests need about a thirtieth of this span
  initial begin
    #400000;
    n_mismatch++;
    test_done;
  end
endmodule
bind bsf_flash_host bsf_flash_host_properties i_prop (.sys_clk, .reset_n, .cmd_valid,
  .cmd_ready, .cmd_op, .rsp_valid, .rsp_error, .chip_sel_n, .write_strobe_n,
  .output_drive_n, .flash_reset_n, .data_lines_oe_n, .ready_busy_out);
